/* dv/flsw_host.sv */
// Serial host model that sends instruction frames to the flash device.
`timescale 1ns/1ps
`default_nettype none

module flsw_host (
   output logic o_sck,
   output logic o_cs_n,
   output logic o_si,
   input wire logic i_so
);
   // A select edge at start clears the link side of the device.
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b0;
      o_si = 1'b0;
      #1 o_cs_n = 1'b1;
   end

   // Sends the top n bits of d MSB first; the clock stands still outside.
   task automatic xfer(input logic [31:0] d, input int n,
         output logic [7:0] rd);
      rd = 8'h00;
      o_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         o_si = d[31-i];
         #6 o_sck = 1'b1;
         rd = {rd[6:0], i_so};
         #6 o_sck = 1'b0;
      end
      #6 o_cs_n = 1'b1;
      o_si = ~o_si;
      #60;
   endtask : xfer
endmodule : flsw_host

`default_nettype wire

/* dv/flsw_status_gate_chk.sv */
// Concurrent checks on the ports of the flash status gate.
`timescale 1ns/1ps
`default_nettype none

module flsw_status_gate_chk
   import flsw_pkg::*;
#(
   parameter int ADDR_W = 24
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_cs_n,
   input wire logic i_op_done,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire logic o_busy,
   input wire logic o_quad_enable,
   input wire logic o_op_start,
   input wire logic [2:0] o_op_kind,
   input wire logic [ADDR_W-1:0] o_op_addr,
   input wire logic [7:0] o_op_data,
   input wire logic o_suspend
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   a_start_busy: assert property (
      o_op_start |=> o_busy && !o_op_start) else $error("start not busy");
   a_busy_ends: assert property (
      $fell(o_busy) |-> $past(i_op_done, 2) || $past(i_op_done, 3))
      else $error("busy fell without done");
   a_done_clears: assert property (
      o_busy && i_op_done |-> ##[1:3] !o_busy) else $error("busy stuck");
   a_quiet_busy: assert property (
      o_busy && !$past(i_op_done) |-> !o_op_start)
      else $error("start while busy");
   a_suspend_busy: assert property (
      o_suspend |-> o_busy && o_op_kind <= OP_ERASE_CHIP)
      else $error("bad suspend");
   a_qe_source: assert property (
      $changed(o_quad_enable) |-> o_op_kind == OP_NV_STATUS &&
      o_quad_enable == o_op_data[STAT_QE_BIT] &&
      ($past(i_op_done) || $past(i_op_done, 2)))
      else $error("quad bit changed");
   a_sector_align: assert property (
      o_op_start && o_op_kind == OP_ERASE_SECTOR |->
      o_op_addr[SECTOR_LSB-1:0] == '0) else $error("sector misaligned");
   a_block_align: assert property (
      o_op_start && o_op_kind == OP_ERASE_LARGE |->
      o_op_addr[BLOCK_LARGE_LSB-1:0] == '0) else $error("block misaligned");
   a_so_quiet: assert property (
      i_cs_n && $past(i_cs_n, 2) |-> !o_so_oe && !o_so)
      else $error("output driven while idle");
endmodule : flsw_status_gate_chk

bind flsw_status_gate flsw_status_gate_chk #(.ADDR_W(ADDR_W)) u_chk (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
   .i_op_done(i_op_done), .o_so(o_so), .o_so_oe(o_so_oe),
   .o_busy(o_busy), .o_quad_enable(o_quad_enable),
   .o_op_start(o_op_start), .o_op_kind(o_op_kind),
   .o_op_addr(o_op_addr), .o_op_data(o_op_data), .o_suspend(o_suspend));

`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the flash status word and write gate.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   fail_count++; $display("Error %0t: got %h want %h", $time, g, e); end end

module tb;
   import flsw_pkg::*;
   logic clk, rstn, sck, cs_n, si, wp_n, done, so, so_oe, busy, qe;
   logic start, susp, srst;
   logic [2:0] kind, k;
   logic [23:0] addr;
   logic [7:0] odata, st, d;
   logic [31:0] lfsr = 32'h43b66b43;
   int fail_count = 0, samples_checked = 0, n_start = 0, n_susp = 0, n0;
   int n_srst = 0;
   logic [7:0] ops [15] = '{OPC_PAGE_PROGRAM, OPC_QUAD_PROG_A,
      OPC_QUAD_PROG_B, OPC_SECTOR_ERASE_A, OPC_SECTOR_ERASE_B,
      OPC_BLOCK_ERASE_SMALL, OPC_BLOCK_ERASE_LARGE, OPC_CHIP_ERASE_A,
      OPC_CHIP_ERASE_B, OPC_STATUS_WRITE, OPC_FUNCTION_WORD_WRITE,
      OPC_READ_PARAMS_NV_SET, OPC_EXT_READ_PARAMS_NV_SET,
      OPC_INFO_ROW_ERASE, OPC_INFO_ROW_PROGRAM};

   flsw_host u_flsw_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));

   flsw_status_gate #(.ADDR_W(24)) u_flsw_status_gate (
      .i_clk_sys(clk), .i_resetn(rstn), .i_sck(sck), .i_cs_n(cs_n),
      .i_si(si), .i_wp_n(wp_n), .i_op_done(done), .o_so(so),
      .o_so_oe(so_oe), .o_busy(busy), .o_quad_enable(qe),
      .o_op_start(start), .o_op_kind(kind), .o_op_addr(addr),
      .o_op_data(odata), .o_suspend(susp), .o_soft_reset(srst));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (start) n_start++;
      if (susp) n_susp++;
      if (srst) n_srst++;
   end

   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt

   function automatic logic [2:0] kind_of(input logic [7:0] o);
      case (o)
         OPC_PAGE_PROGRAM, OPC_QUAD_PROG_A, OPC_QUAD_PROG_B: return OP_PROGRAM;
         OPC_SECTOR_ERASE_A, OPC_SECTOR_ERASE_B: return OP_ERASE_SECTOR;
         OPC_BLOCK_ERASE_SMALL: return OP_ERASE_SMALL;
         OPC_BLOCK_ERASE_LARGE: return OP_ERASE_LARGE;
         OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: return OP_ERASE_CHIP;
         OPC_STATUS_WRITE: return OP_NV_STATUS;
         default: return OP_NV_OTHER;
      endcase
   endfunction : kind_of

   function automatic logic [23:0] addr_of(input logic [2:0] t,
         input logic [23:0] a);
      case (t)
         OP_ERASE_SECTOR: return {a[23:12], 12'h000};
         OP_ERASE_SMALL: return {a[23:15], 15'h0000};
         OP_ERASE_LARGE: return {a[23:16], 16'h0000};
         OP_ERASE_CHIP: return 24'h000000;
         default: return a;
      endcase
   endfunction : addr_of

   task automatic frame(input logic [31:0] f, input int n);
      u_flsw_host.xfer(f, n, st);
      repeat (6) @(posedge clk);
   endtask : frame

   task automatic status_read_cmd(input logic [7:0] e);
      frame({OPC_STATUS_READ, 24'h0}, 24);
      `CHK(st, e)
   endtask : status_read_cmd

   task automatic wr(input logic [7:0] o, input logic [23:0] a,
         input logic en, input logic go);
      n0 = n_start;
      if (en) frame({OPC_WRITE_ENABLE, 24'h0}, 8);
      frame({o, a}, (o == OPC_STATUS_WRITE) ? 16 :
            (kind_of(o) == OP_ERASE_CHIP) ? 8 : 32);
      `CHK(n_start - n0, go ? 1 : 0)
   endtask : wr

   task automatic pulse_done;
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse_done

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      #500000;
      fail_count++;
      wrap_up();
   end

   initial begin
      rstn = 1'b0;
      wp_n = 1'b1;
      done = 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
      `CHK(busy, 1'b0)
      `CHK(qe, 1'b0)
      status_read_cmd(STAT_RESET);
      frame({OPC_WRITE_ENABLE, 24'h0}, 8);
      status_read_cmd(8'h02);
      frame({OPC_WRITE_DISABLE, 24'h0}, 8);
      status_read_cmd(8'h00);
      $display("test latch done");
      foreach (ops[i]) begin
         lfsr = nxt(lfsr);
         k = kind_of(ops[i]);
         wr(ops[i], lfsr[23:0], 1'b0, 1'b0);
         if (k == OP_NV_STATUS) continue;
         wr(ops[i], lfsr[23:0], 1'b1, 1'b1);
         `CHK(kind, k)
         if (k <= OP_ERASE_CHIP) `CHK(addr, addr_of(k, lfsr[23:0]))
         `CHK(busy, 1'b1)
         frame({OPC_WRITE_DISABLE, 24'h0}, 8);
         status_read_cmd(8'h03);
         n0 = n_susp;
         frame({i[0] ? OPC_SUSPEND_A : OPC_SUSPEND_B, 24'h0}, 8);
         `CHK(n_susp - n0, (k <= OP_ERASE_CHIP) ? 1 : 0)
         n0 = n_srst;
         frame({OPC_RESET, 24'h0}, 8);
         `CHK(n_srst - n0, 1)
         pulse_done();
         status_read_cmd(8'h00);
      end
      $display("test gate done");
      lfsr = nxt(lfsr);
      d = {2'b01, 4'h7, lfsr[1:0]};
      wr(OPC_STATUS_WRITE, {d, 16'h0}, 1'b1, 1'b1);
      `CHK(odata, d)
      status_read_cmd(8'h03);
      pulse_done();
      status_read_cmd({d[7:2], 2'b00});
      `CHK(qe, 1'b1)
      wr(OPC_CHIP_ERASE_A, 24'h0, 1'b1, 1'b0);
      wr(OPC_PAGE_PROGRAM, 24'hc00000, 1'b1, 1'b0);
      status_read_cmd({d[7:2], 2'b10});
      wr(OPC_PAGE_PROGRAM, 24'hbfff00, 1'b1, 1'b1);
      pulse_done();
      wp_n <= 1'b0;
      wr(OPC_STATUS_WRITE, {8'h80, 16'h0}, 1'b1, 1'b1);
      pulse_done();
      status_read_cmd(8'h80);
      wr(OPC_STATUS_WRITE, 24'h0, 1'b1, 1'b0);
      status_read_cmd(8'h82);
      wp_n <= 1'b1;
      wr(OPC_STATUS_WRITE, 24'h0, 1'b1, 1'b1);
      pulse_done();
      status_read_cmd(8'h00);
      `CHK(qe, 1'b0)
      $display("test protect done");
      wrap_up();
   end
endmodule : tb

`default_nettype wire

/* include/flsw_pkg.sv */
// Constants shared by the flash status word and write gate logic.
package flsw_pkg;

   // Status word field positions.
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WEL_BIT = 1;
   localparam int STAT_BP_LSB = 2;
   localparam int STAT_BP_MSB = 5;
   localparam int STAT_QE_BIT = 6;
   localparam int STAT_LOCK_BIT = 7;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [5:0] STAT_NV_RESET = 6'h00;

   // Instructions that need the write enable latch.
   localparam logic [7:0] OPC_PAGE_PROGRAM = 8'h02;
   localparam logic [7:0] OPC_QUAD_PROG_A = 8'h32;
   localparam logic [7:0] OPC_QUAD_PROG_B = 8'h38;
   localparam logic [7:0] OPC_SECTOR_ERASE_A = 8'hd7;
   localparam logic [7:0] OPC_SECTOR_ERASE_B = 8'h20;
   localparam logic [7:0] OPC_BLOCK_ERASE_SMALL = 8'h52;
   localparam logic [7:0] OPC_BLOCK_ERASE_LARGE = 8'hd8;
   localparam logic [7:0] OPC_CHIP_ERASE_A = 8'hc7;
   localparam logic [7:0] OPC_CHIP_ERASE_B = 8'h60;
   localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OPC_FUNCTION_WORD_WRITE = 8'h42;
   localparam logic [7:0] OPC_READ_PARAMS_NV_SET = 8'h65;
   localparam logic [7:0] OPC_EXT_READ_PARAMS_NV_SET = 8'h85;
   localparam logic [7:0] OPC_INFO_ROW_ERASE = 8'h64;
   localparam logic [7:0] OPC_INFO_ROW_PROGRAM = 8'h62;
   localparam logic [7:0] OPC_BOOT_CONFIG_WRITE = 8'h15;

   // Instructions whose codes are plain defaults.
   localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OPC_STATUS_READ = 8'h05;
   localparam logic [7:0] OPC_FUNCTION_READ = 8'h48;
   localparam logic [7:0] OPC_EXT_READ_PARAMS_READ = 8'h81;
   localparam logic [7:0] OPC_RESET_ENABLE = 8'h66;
   localparam logic [7:0] OPC_RESET = 8'h99;
   localparam logic [7:0] OPC_SUSPEND_A = 8'h75;
   localparam logic [7:0] OPC_SUSPEND_B = 8'hb0;

   // Frame lengths in serial clock edges.
   localparam logic [5:0] LEN_OPCODE = 6'd8;
   localparam logic [5:0] LEN_STATUS_WRITE = 6'd16;
   localparam logic [5:0] LEN_ADDRESSED = 6'd32;
   localparam logic [5:0] LEN_SATURATE = 6'h3f;

   // Array decode: 4 KB sectors, 32 KB and 64 KB blocks.
   localparam int SECTOR_LSB = 12;
   localparam int BLOCK_SMALL_LSB = 15;
   localparam int BLOCK_LARGE_LSB = 16;
   localparam logic [3:0] BP_ALL_PROTECTED = 4'd9;

   // Operations handed to the array engine.
   localparam logic [2:0] OP_PROGRAM = 3'd0;
   localparam logic [2:0] OP_ERASE_SECTOR = 3'd1;
   localparam logic [2:0] OP_ERASE_SMALL = 3'd2;
   localparam logic [2:0] OP_ERASE_LARGE = 3'd3;
   localparam logic [2:0] OP_ERASE_CHIP = 3'd4;
   localparam logic [2:0] OP_NV_STATUS = 3'd5;
   localparam logic [2:0] OP_NV_OTHER = 3'd6;

   typedef enum logic [1:0] {
      FLSW_READY = 2'b01,
      FLSW_BUSY = 2'b10
   } flsw_state_t;

endpackage : flsw_pkg

/* logic/flsw_status_gate.sv */
// Status word, write enable latch and instruction gate of a serial flash.
`timescale 1ns/1ps
`default_nettype none

module flsw_status_gate
   import flsw_pkg::*;
#(
   parameter int ADDR_W = 24
) (
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic i_wp_n,
   input wire logic i_op_done,
   output logic o_so,
   output logic o_so_oe,
   output logic o_busy,
   output logic o_quad_enable,
   output logic o_op_start,
   output logic [2:0] o_op_kind,
   output logic [ADDR_W-1:0] o_op_addr,
   output logic [7:0] o_op_data,
   output logic o_suspend,
   output logic o_soft_reset
);

   // Serial clock domain: frame capture.
   logic frm_armed_reg;
   logic [5:0] frm_cnt_reg;
   logic [7:0] frm_opc_reg;
   logic [31:0] frm_arg_reg;
   logic [5:0] cur_cnt;
   logic [7:0] opc_now;

   // Serial clock domain: status readback.
   logic req_s1_reg;
   logic req_s2_reg;
   logic ack_tgl_reg;
   logic [7:0] shadow_reg;
   logic [7:0] shift_reg;
   logic rd_active_reg;

   // System domain.
   flsw_state_t state_reg;
   logic busy_reg;
   logic wel_reg;
   logic [5:0] nv_reg;
   logic [5:0] nv_next;
   logic nv_pending_reg;
   logic [7:0] status_word;
   logic [7:0] pub_reg;
   logic req_tgl_reg;
   logic pub_owed_reg;
   logic ack_s1_reg;
   logic ack_s2_reg;
   logic cs_s1_reg;
   logic cs_s2_reg;
   logic cs_s3_reg;
   logic wp_s1_reg;
   logic wp_s2_reg;
   logic commit;

   // Decode of the finished frame.
   logic [ADDR_W-1:0] addr;
   logic [7:0] wr_data;
   logic [3:0] bp;
   logic [7:0] blk;
   logic blk_protected;
   logic needs_wel;
   logic len_ok;
   logic allowed;
   logic [2:0] kind;
   logic [ADDR_W-1:0] kind_addr;

   assign cur_cnt = frm_armed_reg ? frm_cnt_reg : 6'd0;
   assign opc_now = {frm_opc_reg[6:0], i_si};

   // The first edge of a frame restarts the count; the count then saturates at 63.
   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         frm_armed_reg <= 1'b0;
      end else begin
         frm_armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge i_sck) begin
      if (cur_cnt != LEN_SATURATE) begin
         frm_cnt_reg <= cur_cnt + 6'd1;
      end
      if (cur_cnt < LEN_OPCODE) begin
         frm_opc_reg <= opc_now;
      end else if (cur_cnt < LEN_ADDRESSED) begin
         frm_arg_reg <= {frm_arg_reg[30:0], i_si};
      end
   end

   // Status copy is taken over on a toggle handshake from the system side.
   always_ff @(posedge i_sck) begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      ack_tgl_reg <= req_s2_reg;
      if (req_s2_reg != ack_tgl_reg) begin
         shadow_reg <= pub_reg;
      end
   end

   // Status bytes repeat until the frame count saturates at 63 edges.
   always_ff @(posedge i_sck) begin
      if (cur_cnt[2:0] == 3'd7) begin
         shift_reg <= shadow_reg;
      end else begin
         shift_reg <= {shift_reg[6:0], 1'b0};
      end
      if (!frm_armed_reg) begin
         rd_active_reg <= 1'b0;
      end else if (cur_cnt == 6'd7 && opc_now == OPC_STATUS_READ) begin
         rd_active_reg <= 1'b1;
      end
   end

   // Output data changes on the falling edge and floats between frames.
   always_ff @(negedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         o_so <= 1'b0;
         o_so_oe <= 1'b0;
      end else begin
         o_so <= shift_reg[7];
         o_so_oe <= rd_active_reg;
      end
   end

   // Pin synchronisers; the frame is taken when select rises.
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
         wp_s1_reg <= 1'b1;
         wp_s2_reg <= 1'b1;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
      end else begin
         cs_s1_reg <= i_cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
         wp_s1_reg <= i_wp_n;
         wp_s2_reg <= wp_s1_reg;
         ack_s1_reg <= ack_tgl_reg;
         ack_s2_reg <= ack_s1_reg;
      end
   end

   assign commit = cs_s2_reg && !cs_s3_reg && frm_cnt_reg >= LEN_OPCODE;

   assign status_word = {nv_reg, wel_reg, busy_reg};
   assign addr = frm_arg_reg[ADDR_W-1:0];
   assign wr_data = frm_arg_reg[7:0];
   assign bp = nv_reg[STAT_BP_MSB-2:STAT_BP_LSB-2];
   assign blk = addr[ADDR_W-1:BLOCK_LARGE_LSB];

   // Protection counts 64 KB blocks down from the top of the array.
   always_comb begin
      if (bp == 4'd0) begin
         blk_protected = 1'b0;
      end else if (bp >= BP_ALL_PROTECTED) begin
         blk_protected = 1'b1;
      end else begin
         blk_protected = {1'b0, ~blk} < (9'h001 << (bp - 4'd1));
      end
   end

   // Opcode decode into engine operation, alignment and length check.
   always_comb begin
      needs_wel = 1'b1;
      len_ok = frm_cnt_reg >= LEN_ADDRESSED;
      allowed = !blk_protected;
      kind = OP_NV_OTHER;
      kind_addr = addr;
      case (frm_opc_reg)
         OPC_PAGE_PROGRAM, OPC_QUAD_PROG_A, OPC_QUAD_PROG_B: begin
            kind = OP_PROGRAM;
         end
         OPC_SECTOR_ERASE_A, OPC_SECTOR_ERASE_B: begin
            kind = OP_ERASE_SECTOR;
            len_ok = frm_cnt_reg == LEN_ADDRESSED;
            kind_addr[SECTOR_LSB-1:0] = '0;
         end
         OPC_BLOCK_ERASE_SMALL: begin
            kind = OP_ERASE_SMALL;
            len_ok = frm_cnt_reg == LEN_ADDRESSED;
            kind_addr[BLOCK_SMALL_LSB-1:0] = '0;
         end
         OPC_BLOCK_ERASE_LARGE: begin
            kind = OP_ERASE_LARGE;
            len_ok = frm_cnt_reg == LEN_ADDRESSED;
            kind_addr[BLOCK_LARGE_LSB-1:0] = '0;
         end
         OPC_CHIP_ERASE_A, OPC_CHIP_ERASE_B: begin
            kind = OP_ERASE_CHIP;
            len_ok = frm_cnt_reg == LEN_OPCODE;
            allowed = bp == 4'd0;
            kind_addr = '0;
         end
         OPC_STATUS_WRITE: begin
            kind = OP_NV_STATUS;
            len_ok = frm_cnt_reg >= LEN_STATUS_WRITE;
            allowed = !(nv_reg[STAT_LOCK_BIT-2] && !wp_s2_reg);
         end
         OPC_FUNCTION_WORD_WRITE, OPC_READ_PARAMS_NV_SET,
         OPC_EXT_READ_PARAMS_NV_SET, OPC_BOOT_CONFIG_WRITE: begin
            len_ok = frm_cnt_reg >= LEN_STATUS_WRITE;
            allowed = 1'b1;
         end
         OPC_INFO_ROW_ERASE, OPC_INFO_ROW_PROGRAM: begin
            allowed = 1'b1;
         end
         default: begin
            needs_wel = 1'b0;
            len_ok = 1'b0;
            allowed = 1'b0;
         end
      endcase
   end

   // Busy state and the write enable latch.
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state_reg <= FLSW_READY;
         busy_reg <= 1'b0;
         wel_reg <= 1'b0;
         nv_pending_reg <= 1'b0;
      end else begin
         case (state_reg)
            FLSW_READY: begin
               if (commit && frm_opc_reg == OPC_WRITE_ENABLE) begin
                  wel_reg <= 1'b1;
               end else if (commit && frm_opc_reg == OPC_WRITE_DISABLE) begin
                  wel_reg <= 1'b0;
               end else if (commit && needs_wel && wel_reg && len_ok &&
                            allowed) begin
                  state_reg <= FLSW_BUSY;
                  busy_reg <= 1'b1;
                  nv_pending_reg <= kind == OP_NV_STATUS;
               end
            end
            FLSW_BUSY: begin
               if (i_op_done) begin
                  state_reg <= FLSW_READY;
                  busy_reg <= 1'b0;
                  wel_reg <= 1'b0;
                  nv_pending_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= FLSW_READY;
               busy_reg <= 1'b0;
            end
         endcase
      end
   end

   // Nonvolatile bits take the written byte only when the write completes.
   always_comb begin
      nv_next = nv_reg;
      if (state_reg == FLSW_BUSY && i_op_done && nv_pending_reg) begin
         nv_next = o_op_data[STAT_LOCK_BIT:STAT_BP_LSB];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         nv_reg <= STAT_NV_RESET;
      end else begin
         nv_reg <= nv_next;
      end
   end

   // Engine requests, a soft reset pulse in any state, and suspend pulses accepted while a program or erase is busy.
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_op_start <= 1'b0;
         o_op_kind <= OP_PROGRAM;
         o_op_addr <= '0;
         o_op_data <= STAT_RESET;
         o_suspend <= 1'b0;
         o_soft_reset <= 1'b0;
      end else begin
         o_op_start <= 1'b0;
         o_suspend <= 1'b0;
         o_soft_reset <= commit && frm_opc_reg == OPC_RESET;
         if (state_reg == FLSW_READY && commit && needs_wel && wel_reg &&
             len_ok && allowed) begin
            o_op_start <= 1'b1;
            o_op_kind <= kind;
            o_op_addr <= kind_addr;
            o_op_data <= wr_data;
         end
         if (state_reg == FLSW_BUSY && commit &&
             (frm_opc_reg == OPC_SUSPEND_A ||
              frm_opc_reg == OPC_SUSPEND_B) &&
             o_op_kind != OP_NV_STATUS && o_op_kind != OP_NV_OTHER) begin
            o_suspend <= 1'b1;
         end
      end
   end

   // Busy flag and quad enable as registered outputs.
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_busy <= 1'b0;
         o_quad_enable <= 1'b0;
      end else begin
         o_busy <= busy_reg;
         o_quad_enable <= nv_next[STAT_QE_BIT-2];
      end
   end

   // Publish a fresh status copy once the previous one has been taken.
   // One copy is owed after reset, since the link side starts unset.
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         pub_reg <= STAT_RESET;
         req_tgl_reg <= 1'b0;
         pub_owed_reg <= 1'b1;
      end else if (req_tgl_reg == ack_s2_reg &&
                   (pub_reg != status_word || pub_owed_reg)) begin
         pub_reg <= status_word;
         req_tgl_reg <= ~req_tgl_reg;
         pub_owed_reg <= 1'b0;
      end
   end

endmodule : flsw_status_gate

`default_nettype wire
